// File: adc_io_config.sv
// Purpose: Configuration registers and output data interface of a dual
//          channel sampling converter.
// Assumes: APB slave with no wait states; pins and the sampling clock are
//          asynchronous and pass a three-flop filter.
// Notes:   Analog settings leave as registered codes; the output stage
//          launches samples on filtered sampling clock edges.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module adc_io_config
    import adc_cfg_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
)
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Asynchronous pins and sampling clock
    input  wire pins_t             pins_in,
    // Background phase detector, same clock
    input  wire logic              trim_up,
    input  wire logic              trim_dn,
    // Samples from converter core
    input  wire logic              smp_valid,
    input  wire logic [DATA_W-1:0] smp_data,
    output logic                   smp_ready,
    // Output data bus
    output lvds_out_t              lvds_out,
    // Analog settings
    output logic [RNG_W-1:0]       range_i,
    output logic [RNG_W-1:0]       range_q,
    output logic [OFF_W-1:0]       offset_i,
    output logic [OFF_W-1:0]       offset_q,
    output logic [SKEW_W-1:0]      skew_code,
    output logic [TRIM_W-1:0]      phase_trim,
    output logic [DLY_W-1:0]       delay_ps,
    output logic                   swing_high,
    output logic                   demux_1to2,
    output logic                   dual_edge_en
);

    typedef struct packed {
        pins_t              s1;
        pins_t              s2;
        pins_t              s3;
        pins_t              pin_q;
        logic [15:0]        cfg;
        logic [OFF_W-1:0]   off_i;
        logic [OFF_W-1:0]   off_q;
        logic [RNG_W-1:0]   rng_i;
        logic [RNG_W-1:0]   rng_q;
        logic [SKEW_W-1:0]  skew;
        logic [DLY_W-1:0]   dly;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
        logic [TRIM_W-1:0]  trim;
        logic [7:0]         tick;
        lvds_out_t          lvds;
        logic [RNG_W-1:0]   o_rng_i;
        logic [RNG_W-1:0]   o_rng_q;
        logic [OFF_W-1:0]   o_off_i;
        logic [OFF_W-1:0]   o_off_q;
        logic [DLY_W-1:0]   o_dly;
        logic               o_swing;
        logic               o_demux;
        logic               o_des;
    } state_t;

    state_t            st_r;
    state_t            st_n;
    logic [PIN_W-1:0]  agree;
    logic              setup;
    logic              wr;
    logic [IDX_W-1:0]  idx;
    logic              ext_ctl;
    logic              single_rate_edge_select_bit;
    logic              phase90;
    logic              twos;
    logic              des;
    logic              rise;
    logic              fall;
    logic              launch;
    logic              f_valid;
    logic [DATA_W-1:0] f_data;
    logic              f_ready;

    // Index is mapped when the address is aligned and decodes to a register
    function automatic logic reg_known(input logic [7:0] a);
        logic [IDX_W-1:0] i;
        i = a[5:2];
        reg_known = (a[1:0] == 2'h0) && (a[7:6] == 2'h0)
            && (i == IDX_MAIN || i == IDX_IOFF || i == IDX_IRNG || i == IDX_SKEW
            || i == IDX_QOFF || i == IDX_QRNG || i == IDX_DELAY);
    endfunction : reg_known

    // Sample buffer; the output stage drains it on launch edges
    sample_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (smp_valid),
        .in_data   (smp_data),
        .in_ready  (smp_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_ready)
    );

    // Next state
    always_comb
    begin
        st_n = st_r;
        // Three-flop filter; a pin counts once flops two and three agree
        st_n.s1 = pins_in;
        st_n.s2 = st_r.s1;
        st_n.s3 = st_r.s2;
        agree = ~(st_r.s2 ^ st_r.s3);
        st_n.pin_q = pins_t'((agree & st_r.s2) | (~agree & st_r.pin_q));
        rise = st_n.pin_q.conv_clk & ~st_r.pin_q.conv_clk;
        fall = ~st_n.pin_q.conv_clk & st_r.pin_q.conv_clk;

        // Mode decode from filtered pins and main configuration
        ext_ctl = st_r.pin_q.extended_control_mode;
        single_rate_edge_select_bit     = ext_ctl & st_r.cfg[BIT_SDR_MODE];
        phase90 = ext_ctl ? st_r.cfg[BIT_PHASE] : st_r.pin_q.ddr_phase_pin;
        twos    = ext_ctl & st_r.cfg[BIT_TWOS];
        des     = ext_ctl & st_r.cfg[BIT_DES];

        // APB: answer is ready one cycle after setup, no wait states
        setup = psel & ~penable;
        idx   = paddr[5:2];
        wr    = psel & penable & st_r.pready & pwrite & ~st_r.pslverr;
        st_n.pready = setup;
        if (setup)
        begin
            st_n.pslverr = ~reg_known(paddr);
            st_n.prdata  = 32'h0000_0000;
            if (!pwrite && reg_known(paddr))
            begin
                unique case (idx)
                    IDX_MAIN:  st_n.prdata = {16'h0000, st_r.cfg};
                    IDX_IOFF:  st_n.prdata = {19'h00000, st_r.off_i};
                    IDX_IRNG:  st_n.prdata = {17'h00000, st_r.rng_i};
                    IDX_SKEW:  st_n.prdata = {25'h0000000, st_r.skew};
                    IDX_QOFF:  st_n.prdata = {19'h00000, st_r.off_q};
                    IDX_QRNG:  st_n.prdata = {17'h00000, st_r.rng_q};
                    default:   st_n.prdata = {22'h000000, st_r.dly};
                endcase
            end
        end
        else
        begin
            st_n.pslverr = 1'h0;
        end

        // Register writes take effect at the completing access edge
        if (wr)
        begin
            unique case (idx)
                IDX_MAIN:  st_n.cfg   = pwdata[15:0];
                IDX_IOFF:  st_n.off_i = pwdata[OFF_W-1:0];
                IDX_IRNG:  st_n.rng_i = pwdata[RNG_W-1:0];
                IDX_SKEW:  st_n.skew  = pwdata[SKEW_W-1:0];
                IDX_QOFF:  st_n.off_q = pwdata[OFF_W-1:0];
                IDX_QRNG:  st_n.rng_q = pwdata[RNG_W-1:0];
                default:
                begin
                    // Beyond the delay line reach the code saturates
                    st_n.dly = (pwdata[31:0] > 32'(DELAY_MAX_PS))
                        ? DELAY_MAX_PS : pwdata[DLY_W-1:0];
                end
            endcase
        end

        // Analog settings; pin mode maps onto register range values
        st_n.o_rng_i = ext_ctl ? st_r.rng_i
            : (st_r.pin_q.full_scale_range_pin ? RNG_MID : RNG_MIN);
        st_n.o_rng_q = ext_ctl ? st_r.rng_q
            : (st_r.pin_q.full_scale_range_pin ? RNG_MID : RNG_MIN);
        st_n.o_off_i = ext_ctl ? st_r.off_i : RST_OFF;
        st_n.o_off_q = ext_ctl ? st_r.off_q : RST_OFF;
        st_n.o_dly   = ext_ctl ? st_r.dly : '0;
        st_n.o_swing = ext_ctl ? st_r.cfg[BIT_SWING] : 1'h1;
        st_n.o_des   = des;
        // No 1:2 arrangement with double rate under power saving
        st_n.o_demux = st_r.pin_q.demux
            & ~(~single_rate_edge_select_bit & st_r.pin_q.low_rate_power_saving_mode);

        // Background trim runs only in dual-edge mode, manual skew kept apart
        if (des)
        begin
            st_n.tick = (st_r.tick == TRIM_INTERVAL_CYC - 8'h01) ? 8'h00
                : st_r.tick + 8'h01;
            if (st_r.tick == TRIM_INTERVAL_CYC - 8'h01)
            begin
                if (trim_up && !trim_dn && st_r.trim != TRIM_MAX)
                begin
                    st_n.trim = st_r.trim + 4'h1;
                end
                else if (trim_dn && !trim_up && st_r.trim != TRIM_MIN)
                begin
                    st_n.trim = st_r.trim - 4'h1;
                end
            end
        end
        else
        begin
            st_n.tick = 8'h00;
            st_n.trim = 4'h0;
        end

        // Output clock: half rate toggling in double rate, follows the
        // sampling clock in single rate
        if (single_rate_edge_select_bit)
        begin
            if (rise)
            begin
                st_n.lvds.output_data_clock = 1'h1;
            end
            else if (fall)
            begin
                st_n.lvds.output_data_clock = 1'h0;
            end
            launch = st_r.cfg[BIT_SDR_EDGE] ? rise : fall;
        end
        else
        begin
            if (phase90 ? fall : rise)
            begin
                st_n.lvds.output_data_clock = ~st_r.lvds.output_data_clock;
            end
            launch = rise;
        end

        // Launch one word per cell; an empty buffer sends an invalid cell
        f_ready = launch;
        if (launch)
        begin
            st_n.lvds.valid = f_valid;
            if (f_valid)
            begin
                st_n.lvds.data = {f_data[DATA_W-1] ^ twos,
                    f_data[DATA_W-2:0]};
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r       <= '0;
            st_r.cfg   <= RST_MAIN;
            st_r.rng_i <= RNG_MID;
            st_r.rng_q <= RNG_MID;
            st_r.off_i <= RST_OFF;
            st_r.off_q <= RST_OFF;
            st_r.skew  <= RST_SKEW;
            st_r.o_rng_i <= RNG_MIN;
            st_r.o_rng_q <= RNG_MIN;
            st_r.o_swing <= 1'h1;
        end
        else
        begin
            st_r <= st_n;
        end
    end

    // Outputs straight from state flops
    assign prdata       = st_r.prdata;
    assign pready       = st_r.pready;
    assign pslverr      = st_r.pslverr;
    assign lvds_out     = st_r.lvds;
    assign range_i      = st_r.o_rng_i;
    assign range_q      = st_r.o_rng_q;
    assign offset_i     = st_r.o_off_i;
    assign offset_q     = st_r.o_off_q;
    assign skew_code    = st_r.skew;
    assign phase_trim   = st_r.trim;
    assign delay_ps     = st_r.o_dly;
    assign swing_high   = st_r.o_swing;
    assign demux_1to2   = st_r.o_demux;
    assign dual_edge_en = st_r.o_des;

    // Checks on the block's own behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_apb_ready_one: assert property (setup |=> pready ##1 !pready || setup)
        else $error("APB answer not one cycle after setup");
    a_range_ext_reg: assert property (ext_ctl |=> range_i == $past(st_r.rng_i))
        else $error("Range output does not follow register");
    a_range_pin_map: assert property (!ext_ctl && st_r.pin_q.full_scale_range_pin
        |=> range_q == RNG_MID ##0 range_i == RNG_MID)
        else $error("High range pin not mapped to mid value");
    a_offset_pin_zero: assert property (!ext_ctl |=> offset_i == '0 && offset_q == '0)
        else $error("Offset applied outside extended control");
    a_skew_write: assert property (wr && idx == IDX_SKEW |=> skew_code == $past(pwdata[6:0]))
        else $error("Skew write lost");
    a_delay_limit: assert property (delay_ps <= DELAY_MAX_PS)
        else $error("Delay beyond limit");
    a_ddr_zero_deg: assert property (!single_rate_edge_select_bit && !phase90 && rise
        |=> lvds_out.output_data_clock != $past(lvds_out.output_data_clock))
        else $error("0 degree clock did not move with data");
    a_ddr_ninety: assert property (!single_rate_edge_select_bit && phase90 && rise
        |=> $stable(lvds_out.output_data_clock))
        else $error("90 degree clock moved at launch");
    a_sdr_clock: assert property (single_rate_edge_select_bit && rise |=> lvds_out.output_data_clock)
        else $error("Single rate clock did not rise");
    a_twos_msb: assert property (launch && f_valid && twos |=> lvds_out.data[DATA_W-1] == !$past(f_data[DATA_W-1]))
        else $error("Two's complement MSB wrong");
    a_demux_block: assert property (!single_rate_edge_select_bit && st_r.pin_q.low_rate_power_saving_mode
        |=> !demux_1to2)
        else $error("1:2 arrangement offered in power saving");
    a_swing_pin: assert property (!ext_ctl |=> swing_high)
        else $error("Lower swing outside extended control");

    c_ddr_launch: cover property (!single_rate_edge_select_bit && launch && f_valid);
    c_sdr_launch: cover property (single_rate_edge_select_bit && launch && f_valid);
    c_bad_addr:   cover property (setup && !reg_known(paddr));
    c_trim_step:  cover property (des && trim_up ##1 phase_trim != 4'h0);

endmodule : adc_io_config

`default_nettype wire

// File: adc_cfg_pkg.sv
// Purpose: Constants, register map and carrier types of the converter
//          configuration and output block.
// Assumes: APB data 32 bits; register indices become byte address index*4.
// Notes:   Rules below bind this block.
// Function
// - Extended control holds separate 15-bit I and Q range registers, indices 3 and B.
// - Outside extended control, range pin high gives mid value, low gives minimum.
// - Extended control offset per channel: 12-bit magnitude plus sign, indices 2 and A.
// - Skew register index 7 takes codes 0 to 127, default 64, monotonic.
// - Dual-edge mode adds continuous automatic I/Q phase trim beside manual skew.
// - Extended control allows sampling delay up to 825 ps, shifting clocks and data.
// - Double rate: data clock at half data rate, word on every clock edge.
// - Double rate: 0 degree data changes at clock edges, 90 degree edges mid-cell.
// - Double rate phase from phase pin normally, from main bit 14 in extended control.
// - Double rate with low-rate power saving offers no 1:2 demultiplexed output.
// - Single rate: data clock at data rate, data changes on one selected edge.
// - Single rate launch edge selectable only in extended control via main bit 2.
// - Main bit 13 selects higher or lower output swing.
// - Output coding offset binary by default, main bit 4 selects two's complement.
`default_nettype none

package adc_cfg_pkg;

    // Data path widths
    localparam int DATA_W = 12;
    localparam int IDX_W  = 4;
    localparam int RNG_W  = 15;
    localparam int OFF_W  = 13;
    localparam int SKEW_W = 7;
    localparam int DLY_W  = 10;
    localparam int TRIM_W = 4;

    // Register indices; byte address is index times four
    localparam logic [IDX_W-1:0] IDX_MAIN  = 4'h0;
    localparam logic [IDX_W-1:0] IDX_IOFF  = 4'h2;
    localparam logic [IDX_W-1:0] IDX_IRNG  = 4'h3;
    localparam logic [IDX_W-1:0] IDX_SKEW  = 4'h7;
    localparam logic [IDX_W-1:0] IDX_QOFF  = 4'hA;
    localparam logic [IDX_W-1:0] IDX_QRNG  = 4'hB;
    localparam logic [IDX_W-1:0] IDX_DELAY = 4'hC;

    // Main configuration bit positions and the offset sign bit
    localparam int BIT_SDR_EDGE = 2;
    localparam int BIT_TWOS     = 4;
    localparam int BIT_DES      = 7;
    localparam int BIT_SDR_MODE = 9;
    localparam int BIT_SWING    = 13;
    localparam int BIT_PHASE    = 14;
    localparam int OFF_SIGN_BIT = 12;

    // Values after reset, range limits and trim step interval
    localparam logic [15:0]       RST_MAIN  = 16'h2000;
    localparam logic [RNG_W-1:0]  RNG_MID   = 15'h4000;
    localparam logic [RNG_W-1:0]  RNG_MIN   = 15'h0000;
    localparam logic [OFF_W-1:0]  RST_OFF   = 13'h0000;
    localparam logic [SKEW_W-1:0] RST_SKEW  = 7'h40;
    localparam logic [DLY_W-1:0]  DELAY_MAX_PS = 10'h339;
    localparam logic [TRIM_W-1:0] TRIM_MAX  = 4'h7;
    localparam logic [TRIM_W-1:0] TRIM_MIN  = 4'h9;
    localparam logic [7:0]        TRIM_INTERVAL_CYC = 8'h10;

    // Pins from outside the clock domain
    typedef struct packed {
        logic conv_clk;
        logic extended_control_mode;
        logic ddr_phase_pin;
        logic full_scale_range_pin;
        logic low_rate_power_saving_mode;
        logic demux;
    } pins_t;

    localparam int PIN_W = $bits(pins_t);

    // Output data bus toward the capturing logic
    typedef struct packed {
        logic              output_data_clock;
        logic              valid;
        logic [DATA_W-1:0] data;
    } lvds_out_t;

endpackage : adc_cfg_pkg

`default_nettype wire

// File: sample_fifo.sv
// Purpose: Sample buffer between converter core and output stage.
// Assumes: Single clock; DEPTH at least two.
// Notes:   in_ready comes from a flop so the source sees a clean stall.
`timescale 1ns/1ps
`default_nettype none

module sample_fifo
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // Drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
        logic                        space;
    } fifo_st_t;

    fifo_st_t st_r;
    fifo_st_t st_n;
    logic     push;
    logic     pop;

    // Pointer wrap works for any depth, not only powers of two
    always_comb
    begin
        st_n = st_r;
        push = in_valid & st_r.space;
        pop  = out_ready & (st_r.cnt != '0);
        if (push)
        begin
            st_n.mem[st_r.wp] = in_data;
            st_n.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop)
        begin
            st_n.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
        end
        st_n.cnt   = st_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        st_n.space = (st_n.cnt < (AW + 1)'(DEPTH));
    end

    // State register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r       <= '0;
            st_r.space <= 1'h1;
        end
        else
        begin
            st_r <= st_n;
        end
    end

    assign in_ready  = st_r.space;
    assign out_valid = (st_r.cnt != '0);
    assign out_data  = st_r.mem[st_r.rp];

endmodule : sample_fifo

`default_nettype wire

// File: lvds_capture_model.sv
// Purpose: Capturing logic on the far side of the output data bus.
// Assumes: Sampled on pclk; in double rate any change of the data clock marks a launch.
// Notes:   Counts clock toggles so rate checks need no edge timing.
`timescale 1ns/1ps
`default_nettype none

module lvds_capture_model
    import adc_cfg_pkg::*;
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      rst_n,
    // Output data bus
    input  wire lvds_out_t link
);
    logic [DATA_W-1:0] words[$];
    int                toggles = 0;
    logic              output_data_clock_q  = 1'b0;

    // Take a word on each toggle while valid; both edges carry data in DDR
    always @(posedge clk)
    begin
        if (rst_n && link.output_data_clock !== output_data_clock_q)
        begin
            toggles++;
            if (link.valid === 1'b1)
                words.push_back(link.data);
        end
        output_data_clock_q <= link.output_data_clock;
    end
endmodule : lvds_capture_model

`default_nettype wire

// File: adc_io_config_tb.sv
// Purpose: Self-checking bench of the converter configuration block.
// Assumes: APB answers within a bounded wait; conv clock made here.
// Notes:   Conv clock stands still between frames.
`timescale 1ns/1ps
`default_nettype none

module adc_io_config_tb;
    import adc_cfg_pkg::*;
    logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0, prdata, rd;
    logic              pready, pslverr, err, smp_ready, trim_up = 0, trim_dn = 0;
    logic              smp_valid = 0, swing_high, demux_1to2, dual_edge_en;
    logic [DATA_W-1:0] smp_data = 12'h000;
    pins_t             pins = 6'h04;
    lvds_out_t         lvds_out;
    logic [RNG_W-1:0]  range_i, range_q;
    logic [OFF_W-1:0]  offset_i, offset_q;
    logic [SKEW_W-1:0] skew_code;
    logic [TRIM_W-1:0] phase_trim;
    logic [DLY_W-1:0]  delay_ps;
    int                checked = 0, fail_count = 0, cycles = 0;
    logic [7:0]        addrs[7] = '{8'h00, 8'h08, 8'h0C, 8'h1C, 8'h28, 8'h2C, 8'h30};
    logic [31:0]       rst_v[7] = '{32'h2000, 0, 32'h4000, 32'h40, 0, 32'h4000, 0};
    logic [31:0]       full_v[7] = '{0, 32'h1FFF, 32'h7FFF, 32'h7F, 32'h1FFF, 32'h7FFF, 32'h339};

    adc_io_config #(.FIFO_DEPTH(8)) dut
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pins_in(pins), .trim_up(trim_up), .trim_dn(trim_dn), .smp_valid(smp_valid),
        .smp_data(smp_data), .smp_ready(smp_ready), .lvds_out(lvds_out),
        .range_i(range_i), .range_q(range_q), .offset_i(offset_i), .offset_q(offset_q),
        .skew_code(skew_code), .phase_trim(phase_trim), .delay_ps(delay_ps),
        .swing_high(swing_high), .demux_1to2(demux_1to2), .dual_edge_en(dual_edge_en)
    );

    lvds_capture_model cap (.clk(pclk), .rst_n(presetn), .link(lvds_out));

    // Clock and hang guard
    always #25 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            results();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so a following call never reassigns psel in this step
        @(posedge pclk);
    endtask : apb

    // Push rising samples until lim taken or refused
    task automatic fill(input int lim, output int n);
        n = 0;
        smp_valid <= 1'b1;
        smp_data <= 12'h7FC;
        do
        begin
            @(posedge pclk);
            if (smp_ready === 1'b1)
                n++;
            smp_data <= 12'h7FC + n[11:0];
        end
        while (smp_ready === 1'b1 && n < lim);
        smp_valid <= 1'b0;
    endtask : fill

    // n conv periods of 400 ns, then let the filter settle
    task automatic frame(input int n);
        repeat (n)
        begin
            pins.conv_clk <= 1'b1;
            tick(4);
            pins.conv_clk <= 1'b0;
            tick(4);
        end
        tick(8);
    endtask : frame

    task automatic t_map;
        for (int i = 0; i < 7; i++)
        begin
            apb(1'b0, addrs[i], 0);
            chk("reset value", rst_v[i], rd);
        end
        apb(1'b0, 8'h10, 0);
        chk("unmapped error", 1, err);
        for (int i = 1; i < 7; i++)
        begin
            apb(1'b1, addrs[i], 32'hFFFFFFFF);
            apb(1'b0, addrs[i], 0);
            chk("field width", full_v[i], rd);
        end
        $display("test map done");
    endtask : t_map

    task automatic t_modes;
        chk("range pin high", 32'h4000, range_i);
        pins.full_scale_range_pin <= 1'b0; // calibration lies outside this block
        tick(6);
        chk("range pin low", 0, range_q);
        chk("offset off", 0, offset_i);
        chk("delay off", 0, delay_ps);
        pins.extended_control_mode <= 1'b1;
        tick(6);
        chk("range reg", 32'h7FFF, range_i);
        chk("offset reg", 32'h1FFF, offset_q);
        chk("skew code", 32'h7F, skew_code);
        chk("delay max", 32'h339, delay_ps);
        chk("swing high", 1, swing_high);
        apb(1'b1, 8'h00, 0);
        tick(2);
        chk("swing low", 0, swing_high);
        pins.demux <= 1'b1;
        pins.low_rate_power_saving_mode <= 1'b1; // bench clock lies in allowed band
        tick(6);
        chk("demux saving", 0, demux_1to2);
        pins.low_rate_power_saving_mode <= 1'b0;
        tick(6);
        chk("demux normal", 1, demux_1to2);
        pins.demux <= 1'b0;
        apb(1'b1, 8'h00, 32'h80);
        trim_up <= 1'b1;
        tick(40);
        chk("dual edge", 1, dual_edge_en);
        chk("trim moved", 1, phase_trim != 0 && phase_trim <= 3);
        trim_up <= 1'b0;
        apb(1'b1, 8'h00, 0);
        tick(3);
        chk("trim cleared", 0, phase_trim);
        $display("test modes done");
    endtask : t_modes

    task automatic t_stream;
        int n, n0, t0;
        fill(12, n);
        chk("buffer depth", 8, n);
        chk("buffer stall", 0, smp_ready);
        n0 = cap.words.size();
        t0 = cap.toggles;
        frame(8);
        for (int i = 0; i < 8; i++)
            chk("sample order", 32'h7FC + i, cap.words[n0+i]);
        chk("ddr toggles", 8, cap.toggles - t0);
        chk("buffer drained", 1, smp_ready);
        apb(1'b1, 8'h00, 32'h10);
        fill(2, n);
        n0 = cap.words.size();
        frame(2);
        chk("twos word", 32'hFFC, cap.words[n0]);
        chk("twos word", 32'hFFD, cap.words[n0+1]);
        apb(1'b1, 8'h00, 32'h204);
        t0 = cap.toggles;
        frame(4);
        chk("sdr toggles", 8, cap.toggles - t0);
        apb(1'b1, 8'h00, 32'h4000);
        t0 = cap.toggles;
        pins.conv_clk <= 1'b1;
        tick(8);
        chk("ninety at rise", 0, cap.toggles - t0);
        pins.conv_clk <= 1'b0;
        tick(8);
        chk("ninety at fall", 1, cap.toggles - t0);
        $display("test stream done");
    endtask : t_stream

    task automatic results;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        tick(6);
        t_map();
        t_modes();
        t_stream();
        results();
    end
endmodule : adc_io_config_tb

`default_nettype wire
